/* src/ddfr_pkg.sv */
// Constants, types and helpers for the DDR read front end
package ddfr_pkg;
   localparam logic [7:0] OP_DUAL_STD = 8'hBD;
   localparam logic [7:0] OP_DUAL_WIDE = 8'hBE;
   localparam logic [7:0] OP_SINGLE_STD = 8'h0D;
   localparam logic [7:0] OP_SINGLE_WIDE = 8'h0E;
   localparam logic [4:0] INST_LEFT = 5'h07;
   localparam logic [4:0] PREAMBLE_CYCLES = 5'h04;
   localparam logic [4:0] PREAMBLE_LAST = 5'h03;
   localparam logic [5:0] SHORT_FRAME = 6'h08;
   localparam logic [5:0] FRAME_LEN_MAX = 6'h3F;
   localparam logic [31:0] ARRAY_TOP = 32'h00FF_FFFF;
   // Dummy cycles per latency code, high performance and enhanced tables
   localparam logic [4:0] LAT_HP [4] = '{5'h05, 5'h06, 5'h08, 5'h0A};
   localparam logic [4:0] LAT_ENH [4] = '{5'h04, 5'h05, 5'h06, 5'h07};

   typedef struct packed {
      logic ext_addr;
      logic [1:0] lat_code;
      logic enh_table;
      logic train_en;
      logic [7:0] pattern;
   } ddfr_cfg_t;

   localparam ddfr_cfg_t CFG_RESET = '{1'h0, 2'h0, 1'h0, 1'h0, 8'h00};

   typedef enum logic [2:0] {
      PH_INST = 3'h0,
      PH_ADDR = 3'h1,
      PH_MODE = 3'h2,
      PH_DUMMY = 3'h3,
      PH_DATA = 3'h4,
      PH_IGNORE = 3'h5
   } ddfr_phase_t;

   // Address cycles less one: two bits per edge or one bit per edge
   function automatic logic [4:0] addr_left(input logic dual,
                                            input logic wide);
      if (dual)
         addr_left = wide ? 5'h07 : 5'h05;
      else
         addr_left = wide ? 5'h0F : 5'h0B;
   endfunction

   // Cycles less one for one byte of mode or data
   function automatic logic [4:0] byte_left(input logic dual);
      byte_left = dual ? 5'h01 : 5'h03;
   endfunction
endpackage

/* src/ddfr_top.sv */
// DDR dual and single lane read: decode, address, mode, preamble, data out
// What this block does
// - BDh takes three or four address bytes
// - BEh always takes four address bytes
// - Read data leaves two bits per edge for BDh and BEh, one bit per edge on lane one for 0Dh and 0Eh
// - Address and mode enter two bits per edge for BDh and BEh, one bit per edge on lane zero for 0Dh and 0Eh
// - Dummy cycles follow address, or mode with the enhanced table, count from latency code
// - High performance table: instruction, address, latency only
// - Lane values during dummy cycles are ignored
// - Complementary mode nibbles enter continuous read mode
// - Other mode nibbles leave continuous mode next frame
// - Frame of eight cycles or less leaves continuous
// - Address advances by one after every byte
// - Address wraps to zero after the top
// - Hold input ignored during these reads
// - Preamble drives in last four dummy cycles
// - Programmable pattern, same on every active lane
// - Same preamble for single lane 0Dh and 0Eh
`timescale 1ns/100ps
module ddfr_top (
   input wire logic CLK,
   input wire logic RST,
   input wire logic SCK,
   input wire logic CS_N,
   input wire logic SERIAL_LANE_ZERO_IN,
   output logic SERIAL_LANE_ZERO_OUT,
   output logic SERIAL_LANE_ZERO_OE,
   input wire logic SERIAL_LANE_ONE_IN,
   output logic SERIAL_LANE_ONE_OUT,
   output logic SERIAL_LANE_ONE_OE,
   input wire logic EXTENDED_ADDR_FLAG,
   input wire logic [1:0] LATENCY_CODE_FIELD,
   input wire logic ENHANCED_LATENCY_TABLE,
   input wire logic TRAINING_ENABLE,
   input wire logic [7:0] CAPTURE_TRAINING_PATTERN,
   input wire logic [7:0] ARRAY_DATA,
   output logic [31:0] ARRAY_ADDR,
   output logic HOLD_IGNORE,
   output logic EXECUTE_IN_PLACE,
   output logic READ_START
);
   logic link_rst;
   logic cs_meta, cs_idle;
   logic xip_meta;
   logic [2:0] tog_sync;
   ddfr_pkg::ddfr_cfg_t cfg;
   ddfr_pkg::ddfr_phase_t phase, next_phase;
   logic [4:0] left, next_left;
   logic begun, dual, wide, next_dual, next_wide;
   logic [1:0] rise_q, fall_q, fall_pend, q_p, q_n, oe;
   logic [7:0] op_sr, mode_sr, next_mode, opcode, data_byte;
   logic [31:0] addr_sr, next_addr, rd_addr;
   logic xip_flag, xip_dual, xip_wide, read_tog;
   logic [5:0] frame_len;
   logic short_prev, xip_go, accept, mode_end, comp, load_byte;
   logic [4:0] lat;
   logic [3:0] in_nib;
   logic preamble, drive;
   logic [4:0] ci;
   logic [7:0] src, sh;
   logic [1:0] rise_val, fall_val, oe_val;

   // Frame logic is cleared whenever select is high
   assign link_rst = RST | CS_N;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         cs_meta <= 1'h1;
         cs_idle <= 1'h1;
      end else begin
         cs_meta <= CS_N;
         cs_idle <= cs_meta;
      end
   end

   // Settings change only between frames, so the link sees them stable
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         cfg <= ddfr_pkg::CFG_RESET;
      end else if (cs_idle) begin
         cfg <= '{EXTENDED_ADDR_FLAG, LATENCY_CODE_FIELD,
                  ENHANCED_LATENCY_TABLE, TRAINING_ENABLE,
                  CAPTURE_TRAINING_PATTERN};
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         xip_meta <= 1'h0;
         EXECUTE_IN_PLACE <= 1'h0;
      end else begin
         xip_meta <= xip_flag;
         EXECUTE_IN_PLACE <= xip_meta;
      end
   end

   // Toggle crossing turns each accepted read into one pulse
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         tog_sync <= 3'h0;
         READ_START <= 1'h0;
      end else begin
         tog_sync <= {tog_sync[1:0], read_tog};
         READ_START <= tog_sync[1] ^ tog_sync[2];
      end
   end

   assign opcode = {op_sr[6:0], rise_q[0]};
   assign short_prev = frame_len <= ddfr_pkg::SHORT_FRAME;
   assign xip_go = xip_flag & ~short_prev;
   assign lat = cfg.enh_table ? ddfr_pkg::LAT_ENH[cfg.lat_code]
                              : ddfr_pkg::LAT_HP[cfg.lat_code];
   assign in_nib = dual ? {rise_q, fall_q} : {2'h0, rise_q[0], fall_q[0]};
   assign next_addr = dual ? {addr_sr[27:0], in_nib}
                           : {addr_sr[29:0], in_nib[1:0]};
   assign next_mode = dual ? {mode_sr[3:0], in_nib}
                           : {mode_sr[5:0], in_nib[1:0]};
   assign comp = next_mode[7:4] == ~next_mode[3:0];
   assign mode_end = begun && phase == ddfr_pkg::PH_MODE && left == 5'h00;
   assign load_byte = begun && left == 5'h00 &&
      (phase == ddfr_pkg::PH_DUMMY || phase == ddfr_pkg::PH_DATA);
   assign accept = begun ? (phase == ddfr_pkg::PH_INST && left == 5'h00 &&
                            next_phase == ddfr_pkg::PH_ADDR)
                         : xip_go;

   always_comb begin
      next_phase = phase;
      next_left = left;
      next_dual = dual;
      next_wide = wide;
      if (!begun) begin
         if (xip_go) begin
            // continuous frame starts at the address
            next_phase = ddfr_pkg::PH_ADDR;
            next_dual = xip_dual;
            next_wide = xip_wide;
            next_left = ddfr_pkg::addr_left(xip_dual, xip_wide);
         end else begin
            next_phase = ddfr_pkg::PH_INST;
            next_left = ddfr_pkg::INST_LEFT;
         end
      end else if (left != 5'h00) begin
         next_left = left - 5'h01;
      end else begin
         case (phase)
            ddfr_pkg::PH_INST: begin
               next_phase = ddfr_pkg::PH_ADDR;
               case (opcode)
                  ddfr_pkg::OP_DUAL_STD: begin
                     next_dual = 1'h1;
                     next_wide = cfg.ext_addr;
                  end
                  ddfr_pkg::OP_DUAL_WIDE: begin
                     next_dual = 1'h1;
                     next_wide = 1'h1;
                  end
                  ddfr_pkg::OP_SINGLE_STD: begin
                     next_dual = 1'h0;
                     next_wide = cfg.ext_addr;
                  end
                  ddfr_pkg::OP_SINGLE_WIDE: begin
                     next_dual = 1'h0;
                     next_wide = 1'h1;
                  end
                  default: begin
                     next_phase = ddfr_pkg::PH_IGNORE;
                  end
               endcase
               next_left = ddfr_pkg::addr_left(next_dual, next_wide);
            end
            ddfr_pkg::PH_ADDR: begin
               // no mode cycles with the high performance table
               if (cfg.enh_table) begin
                  next_phase = ddfr_pkg::PH_MODE;
                  next_left = ddfr_pkg::byte_left(dual);
               end else begin
                  next_phase = ddfr_pkg::PH_DUMMY;
                  next_left = lat - 5'h01;
               end
            end
            ddfr_pkg::PH_MODE: begin
               next_phase = ddfr_pkg::PH_DUMMY;
               next_left = lat - 5'h01;
            end
            ddfr_pkg::PH_DUMMY, ddfr_pkg::PH_DATA: begin
               next_phase = ddfr_pkg::PH_DATA;
               next_left = ddfr_pkg::byte_left(dual);
            end
            ddfr_pkg::PH_IGNORE: begin
               next_phase = ddfr_pkg::PH_IGNORE;
            end
            default: begin
               next_phase = ddfr_pkg::PH_IGNORE;
            end
         endcase
      end
   end

   // Rising edge: sample lanes, step the frame; bits of a cycle are
   // absorbed at the rising edge that ends it
   always_ff @(posedge SCK or posedge link_rst) begin
      if (link_rst) begin
         begun <= 1'h0;
         phase <= ddfr_pkg::PH_INST;
         left <= 5'h00;
         dual <= 1'h0;
         wide <= 1'h0;
         rise_q <= 2'h0;
      end else begin
         begun <= 1'h1;
         phase <= next_phase;
         left <= next_left;
         dual <= next_dual;
         wide <= next_wide;
         rise_q <= {SERIAL_LANE_ONE_IN, SERIAL_LANE_ZERO_IN};
      end
   end

   always_ff @(posedge SCK or posedge link_rst) begin
      if (link_rst) begin
         op_sr <= 8'h00;
         addr_sr <= 32'h0000_0000;
         mode_sr <= 8'h00;
      end else if (begun) begin
         if (phase == ddfr_pkg::PH_INST)
            op_sr <= opcode;
         if (phase == ddfr_pkg::PH_ADDR)
            addr_sr <= next_addr;
         if (phase == ddfr_pkg::PH_MODE)
            mode_sr <= next_mode;
      end
   end

   always_ff @(posedge SCK or posedge RST) begin
      if (RST) begin
         rd_addr <= 32'h0000_0000;
         data_byte <= 8'h00;
      end else if (begun && phase == ddfr_pkg::PH_ADDR && left == 5'h00) begin
         rd_addr <= next_addr;
      end else if (load_byte) begin
         data_byte <= ARRAY_DATA;
         rd_addr <= rd_addr == ddfr_pkg::ARRAY_TOP ? 32'h0000_0000
                                                   : rd_addr + 32'h1;
      end
   end
   assign ARRAY_ADDR = rd_addr;

   // Continuous mode state lives across frames
   always_ff @(posedge SCK or posedge RST) begin
      if (RST) begin
         xip_flag <= 1'h0;
         xip_dual <= 1'h0;
         xip_wide <= 1'h0;
         frame_len <= 6'h00;
         read_tog <= 1'h0;
      end else begin
         frame_len <= !begun ? 6'h01 :
            (frame_len == ddfr_pkg::FRAME_LEN_MAX ? frame_len
                                                 : frame_len + 6'h01);
         if (accept)
            read_tog <= ~read_tog;
         if (!begun && xip_flag && short_prev) begin
            xip_flag <= 1'h0;
         end else if (mode_end) begin
            // mode nibbles decide the next frame
            xip_flag <= comp;
            xip_dual <= dual;
            xip_wide <= wide;
         end
      end
   end

   // hold ignored while a read runs
   always_ff @(posedge SCK or posedge link_rst) begin
      if (link_rst)
         HOLD_IGNORE <= 1'h0;
      else if (accept)
         HOLD_IGNORE <= 1'h1;
   end

   // last four dummy cycles carry the pattern
   assign preamble = cfg.train_en && next_phase == ddfr_pkg::PH_DUMMY &&
                     next_left < ddfr_pkg::PREAMBLE_CYCLES;
   assign drive = preamble || next_phase == ddfr_pkg::PH_DATA;
   assign ci = preamble ? ddfr_pkg::PREAMBLE_LAST - next_left
                        : ddfr_pkg::byte_left(next_dual) - next_left;
   assign src = preamble ? cfg.pattern : (load_byte ? ARRAY_DATA : data_byte);
   assign sh = (preamble || !next_dual) ? 8'(src << {ci, 1'b0})
                                        : 8'(src << {ci, 2'b00});

   always_comb begin
      if (preamble) begin
         // same pattern bit on each active lane
         rise_val = {sh[7], sh[7] & next_dual};
         fall_val = {sh[6], sh[6] & next_dual};
      end else if (next_dual) begin
         rise_val = sh[7:6];
         fall_val = sh[5:4];
      end else begin
         rise_val = {sh[7], 1'b0};
         fall_val = {sh[6], 1'b0};
      end
      // lanes stay undriven outside preamble and data
      oe_val = {drive, drive & next_dual};
   end

   // Lane value is q_p ^ q_n: each edge sets its own half of the pair
   always_ff @(posedge SCK or posedge link_rst) begin
      if (link_rst) begin
         q_p <= 2'h0;
         fall_pend <= 2'h0;
         oe <= 2'h0;
      end else begin
         q_p <= rise_val ^ q_n;
         fall_pend <= fall_val;
         oe <= oe_val;
      end
   end

   always_ff @(negedge SCK or posedge link_rst) begin
      if (link_rst) begin
         q_n <= 2'h0;
         fall_q <= 2'h0;
      end else begin
         q_n <= fall_pend ^ q_p;
         fall_q <= {SERIAL_LANE_ONE_IN, SERIAL_LANE_ZERO_IN};
      end
   end

   assign SERIAL_LANE_ONE_OUT = q_p[1] ^ q_n[1];
   assign SERIAL_LANE_ZERO_OUT = q_p[0] ^ q_n[0];
   assign SERIAL_LANE_ONE_OE = oe[1];
   assign SERIAL_LANE_ZERO_OE = oe[0];

   AST_BD_WIDTH: assert property (@(posedge SCK) disable iff (link_rst)
      (begun && phase == ddfr_pkg::PH_INST && left == 5'h00 &&
       opcode == ddfr_pkg::OP_DUAL_STD) |=> (wide == cfg.ext_addr && dual))
      else $error("BDh address width wrong");
   AST_BE_WIDE: assert property (@(posedge SCK) disable iff (link_rst)
      (begun && phase == ddfr_pkg::PH_INST && left == 5'h00 &&
       opcode == ddfr_pkg::OP_DUAL_WIDE) |=> (wide && left == 5'h07))
      else $error("BEh not four address bytes");
   AST_DUAL_DRIVE: assert property (@(posedge SCK) disable iff (link_rst)
      (phase == ddfr_pkg::PH_DATA && dual) |-> (oe == 2'h3))
      else $error("Dual data not on both lanes");
   AST_DUMMY_COUNT: assert property (@(posedge SCK) disable iff (link_rst)
      ($rose(phase == ddfr_pkg::PH_DUMMY)) |-> (left == lat - 5'h01))
      else $error("Dummy count differs from latency code");
   AST_QUIET_DUMMY: assert property (@(posedge SCK) disable iff (link_rst)
      (phase == ddfr_pkg::PH_DUMMY && oe != 2'h0) |->
      (cfg.train_en && left < ddfr_pkg::PREAMBLE_CYCLES))
      else $error("Lanes driven early in dummy cycles");
   AST_XIP_ENTER: assert property (@(posedge SCK) disable iff (RST)
      (mode_end && comp) |=> xip_flag)
      else $error("Complementary mode did not enter continuous");
   AST_XIP_LEAVE: assert property (@(posedge SCK) disable iff (RST)
      (mode_end && !comp) |=> !xip_flag)
      else $error("Other mode kept continuous");
   AST_SHORT_EXIT: assert property (@(posedge SCK) disable iff (RST)
      (!begun && xip_flag && frame_len <= ddfr_pkg::SHORT_FRAME) |=>
      (!xip_flag && phase != ddfr_pkg::PH_ADDR))
      else $error("Short frame did not leave continuous");
   AST_ADDR_STEP: assert property (@(posedge SCK) disable iff (RST)
      (load_byte && rd_addr != ddfr_pkg::ARRAY_TOP) |=>
      (rd_addr == $past(rd_addr) + 32'h1))
      else $error("Address did not advance by one");
   AST_ADDR_WRAP: assert property (@(posedge SCK) disable iff (RST)
      (load_byte && rd_addr == ddfr_pkg::ARRAY_TOP) |=>
      (rd_addr == 32'h0000_0000))
      else $error("Address did not wrap to zero");
   AST_HOLD_MASK: assert property (@(posedge SCK) disable iff (link_rst)
      (phase == ddfr_pkg::PH_DATA) |-> HOLD_IGNORE)
      else $error("Hold not ignored during data");
   AST_SAME_LANES: assert property (@(negedge SCK) disable iff (link_rst)
      (phase == ddfr_pkg::PH_DUMMY && dual && oe == 2'h3) |->
      (SERIAL_LANE_ONE_OUT == SERIAL_LANE_ZERO_OUT))
      else $error("Pattern differs between lanes");
   AST_SINGLE_LANE: assert property (@(posedge SCK) disable iff (link_rst)
      (phase == ddfr_pkg::PH_DATA && !dual) |-> (oe == 2'h2))
      else $error("Single lane read drives lane zero");

   COV_XIP: cover property (@(posedge SCK) disable iff (RST)
      (mode_end && comp));
   COV_WRAP: cover property (@(posedge SCK) disable iff (RST)
      (load_byte && rd_addr == ddfr_pkg::ARRAY_TOP));
   COV_PREAMBLE: cover property (@(posedge SCK) disable iff (link_rst)
      (phase == ddfr_pkg::PH_DUMMY && oe == 2'h3));
   COV_SINGLE: cover property (@(posedge SCK) disable iff (link_rst)
      (phase == ddfr_pkg::PH_DATA && !dual));
endmodule

/* verif/ddfr_host.sv */
// SPI host model: drives link clock, select and lanes, captures replies
`timescale 1ns/100ps
module ddfr_host (
   output logic sck,
   output logic cs_n,
   input wire logic dev_out0,
   input wire logic dev_oe0,
   input wire logic dev_out1,
   input wire logic dev_oe1,
   output wire logic lane0,
   output wire logic lane1
);
   logic [1:0] drv_en;
   logic [1:0] drv_val;
   logic [1:0] last_val;
   logic [3:0] g [64];
   logic oe [64];
   logic [7:0] pat0;
   logic [7:0] pat1;
   logic [3:0] oe_pre;
   logic oe_early;
   logic oe_any;
   logic one_lane;
   logic [7:0] rx [$];
   int n;
   // Released lanes show the inverse of their last driven level
   assign lane0 = dev_oe0 ? dev_out0 : drv_en[0] ? drv_val[0] : ~last_val[0];
   assign lane1 = dev_oe1 ? dev_out1 : drv_en[1] ? drv_val[1] : ~last_val[1];
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      drv_en = 2'h0;
      drv_val = 2'h0;
      last_val = 2'h0;
      one_lane = 1'b0;
      n = 0;
   end
   task automatic put(input logic [1:0] v, input logic [1:0] en);
      last_val = (v & en) | (last_val & ~en);
      drv_val = v;
      drv_en = en;
   endtask
   // 32 ns cycle, a bit pair per edge
   task automatic cyc(input logic [3:0] nib, input logic [1:0] en);
      put(nib[3:2], en);
      #14;
      if (n > 0)
         g[n-1][1:0] = {lane1, lane0};
      #1 sck = 1'b1;
      #1 put(nib[1:0], en);
      #14 g[n][3:2] = {lane1, lane0};
      oe[n] = one_lane ? dev_oe1 & ~dev_oe0 : dev_oe0 & dev_oe1;
      #1 sck = 1'b0;
      #1 n++;
   endtask
   task automatic frame(input logic op_on, input logic [7:0] op,
                        input logic [31:0] a, input int acyc, input int mcyc,
                        input logic [7:0] mode, input int dum, input int nb);
      int i;
      int d;
      n = 0;
      rx.delete();
      cs_n = 1'b0;
      if (op_on)
         for (i = 0; i < 8; i++)
            cyc({1'b0, op[7-i], 1'b0, op[7-i]}, 2'b01);
      for (i = 0; i < acyc; i++)
         if (one_lane)
            cyc({1'b0, a[2*(acyc-1-i)+1], 1'b0, a[2*(acyc-1-i)]}, 2'b01);
         else
            cyc(4'(a >> (4 * (acyc - 1 - i))), 2'b11);
      for (i = 0; i < mcyc; i++)
         cyc(i == 0 ? mode[7:4] : mode[3:0], 2'b11);
      d = n + dum;
      for (i = 0; i < dum + (one_lane ? 4 : 2) * nb; i++)
         cyc(4'h0, 2'b00);
      #14 g[n-1][1:0] = {lane1, lane0};
      // select held through mode, dummy and data
      #2 cs_n = 1'b1;
      put(2'b00, 2'b00);
      oe_early = 1'b0;
      oe_any = 1'b0;
      for (i = 0; i < n; i++) begin
         oe_any |= oe[i];
         if (i >= d - dum && i < d - 4)
            oe_early |= oe[i];
      end
      for (i = 0; i < 4; i++) begin
         {pat1[7-2*i], pat0[7-2*i]} = g[d-4+i][3:2];
         {pat1[6-2*i], pat0[6-2*i]} = g[d-4+i][1:0];
         oe_pre[3-i] = oe[d-4+i];
      end
      // single lane: lane one only, four cycles per byte
      for (i = 0; i < nb; i++)
         if (one_lane)
            rx.push_back({g[d+4*i][3], g[d+4*i][1], g[d+4*i+1][3],
                          g[d+4*i+1][1], g[d+4*i+2][3], g[d+4*i+2][1],
                          g[d+4*i+3][3], g[d+4*i+3][1]});
         else
            rx.push_back({g[d+2*i], g[d+2*i+1]});
   endtask
endmodule

/* verif/ddfr_top_test.sv */
// Self-checking bench for the DDR read front end
`timescale 1ns/100ps
module ddfr_top_test;
   logic clk, rst, sck, cs_n, lane0, lane1, out0, oe0, out1, oe1;
   logic ext, enh, train, hold, execute_in_place, hold_seen, rstart;
   int starts;
   logic [1:0] code;
   logic [7:0] pat;
   logic [7:0] adata;
   logic [31:0] aaddr;
   int errors;
   int num_checks;
   function automatic logic [7:0] dat(input logic [31:0] a);
      return a[7:0] ^ {a[24], 7'h00} ^ 8'h3C;
   endfunction
   assign adata = dat(aaddr);
   ddfr_top ddfr_top_inst (.CLK(clk), .RST(rst), .SCK(sck), .CS_N(cs_n),
      .SERIAL_LANE_ZERO_IN(lane0), .SERIAL_LANE_ZERO_OUT(out0),
      .SERIAL_LANE_ZERO_OE(oe0), .SERIAL_LANE_ONE_IN(lane1),
      .SERIAL_LANE_ONE_OUT(out1), .SERIAL_LANE_ONE_OE(oe1),
      .EXTENDED_ADDR_FLAG(ext), .LATENCY_CODE_FIELD(code),
      .ENHANCED_LATENCY_TABLE(enh), .TRAINING_ENABLE(train),
      .CAPTURE_TRAINING_PATTERN(pat), .ARRAY_DATA(adata),
      .ARRAY_ADDR(aaddr), .HOLD_IGNORE(hold), .EXECUTE_IN_PLACE(execute_in_place),
      .READ_START(rstart));
   ddfr_host ddfr_host_inst (.sck(sck), .cs_n(cs_n), .dev_out0(out0),
      .dev_oe0(oe0), .dev_out1(out1), .dev_oe1(oe1), .lane0(lane0),
      .lane1(lane1));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge sck)
      if (cs_n === 1'b0 && hold === 1'b1)
         hold_seen = 1'b1;
   // Pulse is launched on the rising edge, so count it on the falling one
   always @(negedge clk)
      if (rstart === 1'b1)
         starts++;
   task automatic check(input logic ok, input string msg);
      num_checks++;
      if (ok !== 1'b1) begin
         errors++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask
   task automatic wrap_up;
      if (errors == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic setup(input logic e, input logic [1:0] c, input logic h,
                        input logic t, input logic [7:0] p);
      @(negedge clk);
      ext = e;
      code = c;
      enh = h;
      train = t;
      pat = p;
      hold_seen = 1'b0;
      repeat (5) @(negedge clk);
   endtask
   // One frame, settle, then compare the streamed bytes
   task automatic xfer(input logic op_on, input logic [7:0] op,
                       input logic [31:0] a, input int acyc, input int mcyc,
                       input logic [7:0] mode, input int dum, input int nb);
      int i;
      int s;
      s = starts;
      ddfr_host_inst.frame(op_on, op, a, acyc, mcyc, mode, dum, nb);
      repeat (10) @(negedge clk);
      check(starts == s + 1, "read start count");
      for (i = 0; i < nb; i++)
         check(ddfr_host_inst.rx[i] === dat((a + i) & ddfr_pkg::ARRAY_TOP),
               "data byte");
   endtask
   task automatic t_read(input logic [7:0] op, input logic e, input int acyc,
                         input logic [1:0] c, input logic [31:0] a,
                         input logic [7:0] p, input logic t);
      ddfr_host_inst.one_lane = (op == ddfr_pkg::OP_SINGLE_STD ||
                                 op == ddfr_pkg::OP_SINGLE_WIDE);
      setup(e, c, 1'b0, t, p);
      xfer(1'b1, op, a, acyc, 0, 8'h00, ddfr_pkg::LAT_HP[c], 4);
      check(hold_seen === 1'b1, "hold not ignored");
      check(ddfr_host_inst.oe_early === 1'b0, "early drive");
      check(ddfr_host_inst.oe_pre === (t ? 4'hF : 4'h0), "preamble");
      if (t)
         check(ddfr_host_inst.pat1 === p && (ddfr_host_inst.one_lane ||
               ddfr_host_inst.pat0 === p), "pattern");
      check(execute_in_place === 1'b0, "continuous set");
   endtask
   task automatic t_cont;
      logic [7:0] bd;
      int d;
      bd = ddfr_pkg::OP_DUAL_STD;
      d = ddfr_pkg::LAT_ENH[0];
      setup(1'b0, 2'h0, 1'b1, 1'b1, 8'h34);
      xfer(1'b1, bd, 32'h00102030, 6, 2, 8'hA5, d, 2);
      check(execute_in_place === 1'b1, "no entry");
      xfer(1'b0, 8'h00, 32'h00405060, 6, 2, 8'h5A, d, 2);
      check({ddfr_host_inst.pat1, ddfr_host_inst.pat0} === 16'h3434,
            "pattern");
      xfer(1'b0, 8'h00, 32'h00708090, 6, 2, 8'h00, d, 2);
      xfer(1'b1, bd, 32'h00A0B0C0, 6, 2, 8'h00, d, 2);
      check(execute_in_place === 1'b0, "no exit");
      xfer(1'b1, bd, 32'h00C0D0E0, 6, 2, 8'hF0, d, 2);
      check(execute_in_place === 1'b1, "no reentry");
      ddfr_host_inst.frame(1'b0, 8'h00, 32'h0, 4, 0, 8'h00, 0, 0);
      repeat (5) @(negedge clk);
      xfer(1'b1, bd, 32'h00E0F000, 6, 2, 8'h00, d, 2);
      check(execute_in_place === 1'b0, "no short exit");
   endtask
   task automatic t_bad;
      int s;
      setup(1'b0, 2'h0, 1'b0, 1'b1, 8'h34);
      s = starts;
      ddfr_host_inst.frame(1'b1, 8'h03, 32'h00010203, 6, 0, 8'h00, 5, 2);
      repeat (10) @(negedge clk);
      check(ddfr_host_inst.oe_any === 1'b0, "drove on bad opcode");
      check(starts == s, "start on bad opcode");
   endtask
   initial begin
      errors = 0;
      num_checks = 0;
      starts = 0;
      rst = 1'b1;
      ext = 1'b0;
      code = 2'h0;
      enh = 1'b0;
      train = 1'b0;
      pat = 8'h00;
      hold_seen = 1'b0;
      repeat (8) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      t_read(ddfr_pkg::OP_DUAL_STD, 0, 6, 0, 32'h00ABCDEF, 8'h34, 1);
      t_read(ddfr_pkg::OP_DUAL_STD, 1, 8, 1, 32'h00C3A5F1, 8'hC9, 1);
      t_read(ddfr_pkg::OP_DUAL_WIDE, 0, 8, 2, 32'h005A6B7C, 8'h5A, 0);
      t_read(ddfr_pkg::OP_SINGLE_STD, 1, 16, 1, 32'h00123456, 8'h34, 1);
      t_read(ddfr_pkg::OP_DUAL_WIDE, 1, 8, 3, 32'h00FEDCBA, 8'h96, 1);
      t_read(ddfr_pkg::OP_DUAL_STD, 0, 6, 0, 32'h00FFFFFE, 8'h0F, 0);
      t_cont();
      t_bad();
      wrap_up();
   end
   initial begin
      #200000;
      errors++;
      wrap_up();
   end
endmodule
